// file: sync_rx_map.vh
// constants for the clock-synchronous slave receiver
`ifndef SYNC_RX_MAP_VH
`define SYNC_RX_MAP_VH
`define PROTECT_KEY       16'hA502
`define BITS_PER_CHAR     4'h8
`define SESSION_BYTES     6'h20
`define BIT_RATE_KBPS     100
`endif

// file: sync_rx_shifter.v
// serial-in shifter assembling one lsb-first character
module sync_rx_shifter #(
   parameter WIDTH = 8
) (
   input  wire             i_core_clk,  // core clock
   input  wire             i_reset_n,   // async reset, active low
   input  wire             i_clear,     // restart character
   input  wire             i_sample,    // one-cycle sampling strobe
   input  wire             i_bit,       // synchronised data bit
   output reg  [WIDTH-1:0] o_data,      // assembled character
   output reg              o_done       // one-cycle: character complete
);
   reg [WIDTH-1:0] shift_reg;
   reg [3:0]       count_reg;

   always @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         shift_reg <= {WIDTH{1'b0}};
         count_reg <= 4'h0;
         o_data    <= {WIDTH{1'b0}};
         o_done    <= 1'b0;
      end else begin
         o_done <= 1'b0;
         if (i_clear) begin
            count_reg <= 4'h0;
         end else if (i_sample) begin
            shift_reg <= {i_bit, shift_reg[WIDTH-1:1]};
            if (count_reg == WIDTH - 1) begin
               count_reg <= 4'h0;
               o_data    <= {i_bit, shift_reg[WIDTH-1:1]};
               o_done    <= 1'b1;
            end else begin
               count_reg <= count_reg + 4'h1;
            end
         end
      end
   end
endmodule // sync_rx_shifter

// file: sync_serial_slave_receiver.v
// clock-synchronous slave receiver with session and indicator logic
`include "sync_rx_map.vh"
module sync_serial_slave_receiver #(
   parameter WIDTH = 8
) (
   input  wire             i_core_clk,     // core clock, 10 MHz
   input  wire             i_reset_n,      // async reset, active low
   input  wire             i_sync_clock_in,// external bit clock pin
   input  wire             i_serial_data_in,// serial data pin
   input  wire             i_key_wr,       // one-cycle key write strobe
   input  wire [15:0]      i_key_data,     // key value written
   input  wire             i_module_stop,  // level: module stop request
   input  wire             i_rx_enable,    // level: receive enable
   input  wire             i_data_read,    // one-cycle: byte read
   input  wire             i_flag_clear,   // one-cycle: clear request flag
   output reg  [WIDTH-1:0] o_rx_data,      // receive data register
   output reg              o_rx_full_request_flag, // sticky request flag
   output reg              o_rx_full_irq,  // one-cycle full request
   output reg              o_rx_error_irq, // one-cycle error request
   output reg              o_start_indicator, // session started
   output reg              o_done_indicator,  // session finished
   output reg              o_error_indicator, // receive error seen
   output reg              o_running       // channel out of stop
);
   // ----------------------------------------------------------------
   // bit clock synchroniser and edge detect
   // ----------------------------------------------------------------
   reg [2:0] sck_reg;
   always @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sck_reg <= 3'h0;
      end else begin
         sck_reg <= {sck_reg[1:0], i_sync_clock_in};
      end
   end
   // third stage only delays the synchronised level for the edge test
   wire sck_rise = sck_reg[1] & ~sck_reg[2];

   // ----------------------------------------------------------------
   // data synchroniser, same depth as the clock path
   // ----------------------------------------------------------------
   reg [1:0] sdi_reg;
   always @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sdi_reg <= 2'h0;
      end else begin
         sdi_reg <= {sdi_reg[0], i_serial_data_in};
      end
   end

   // ----------------------------------------------------------------
   // protection key check
   // ----------------------------------------------------------------
   reg key_ok_reg;
   always @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         key_ok_reg <= 1'b0;
      end else if (i_key_wr) begin
         // any other value clears the key match; a channel already running stays on until module stop
         key_ok_reg <= (i_key_data == `PROTECT_KEY);
      end
   end

   // ----------------------------------------------------------------
   // module stop state
   // ----------------------------------------------------------------
   always @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_running <= 1'b0;
      end else begin
         if (i_module_stop)
            o_running <= 1'b0;
         else if (key_ok_reg)
            o_running <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // session state machine
   // ----------------------------------------------------------------
   localparam ST_IDLE = 2'b00;
   localparam ST_RECV = 2'b01;
   localparam ST_DONE = 2'b10;
   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg [5:0] count_reg;
   reg       unread_reg;
   wire active = o_running & i_rx_enable & (state_reg == ST_RECV);
   wire [WIDTH-1:0] shift_data;
   wire             shift_done;
   wire             byte_done = shift_done & active;

   // true when the byte now completing closes the session
   function last_byte;
      input [5:0] count;
      begin
         last_byte = (count == `SESSION_BYTES - 6'h01);
      end
   endfunction

   sync_rx_shifter #(.WIDTH(WIDTH)) u_shifter (
      .i_core_clk (i_core_clk),
      .i_reset_n  (i_reset_n),
      .i_clear    (~active),
      .i_sample   (sck_rise & active),
      .i_bit      (sdi_reg[1]),
      .o_data     (shift_data),
      .o_done     (shift_done)
   );

   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (o_running & i_rx_enable)
               state_next = ST_RECV;
         end
         ST_RECV: begin
            if (!o_running)
               state_next = ST_IDLE;
            else if (byte_done && last_byte(count_reg))
               state_next = ST_DONE;
         end
         ST_DONE: begin
            // a new session needs enable to drop or the channel to stop first
            if (!o_running || !i_rx_enable)
               state_next = ST_IDLE;
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   wire session_start = (state_reg == ST_IDLE) & (state_next == ST_RECV);
   wire overrun       = byte_done & unread_reg & ~i_data_read;

   // ----------------------------------------------------------------
   // state register and session byte counter
   // ----------------------------------------------------------------
   always @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_reg <= ST_IDLE;
         count_reg <= 6'h00;
      end else begin
         state_reg <= state_next;
         if (session_start)
            count_reg <= 6'h00;
         else if (byte_done)
            count_reg <= count_reg + 6'h01;
      end
   end

   // ----------------------------------------------------------------
   // receive data register and request pulses
   // ----------------------------------------------------------------
   always @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_rx_data      <= {WIDTH{1'b0}};
         o_rx_full_irq  <= 1'b0;
         o_rx_error_irq <= 1'b0;
      end else begin
         o_rx_full_irq  <= byte_done;
         o_rx_error_irq <= overrun;
         // an overrun still replaces the unread byte
         if (byte_done)
            o_rx_data <= shift_data;
      end
   end

   // ----------------------------------------------------------------
   // unread tracking and polled request flag, set wins over clear
   // ----------------------------------------------------------------
   always @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         unread_reg             <= 1'b0;
         o_rx_full_request_flag <= 1'b0;
      end else begin
         if (byte_done)
            unread_reg <= 1'b1;
         else if (i_data_read)
            unread_reg <= 1'b0;
         if (byte_done)
            o_rx_full_request_flag <= 1'b1;
         else if (i_flag_clear)
            o_rx_full_request_flag <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // start, done and error indicators
   // ----------------------------------------------------------------
   always @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_start_indicator <= 1'b0;
         o_done_indicator  <= 1'b0;
         o_error_indicator <= 1'b0;
      end else begin
         if (session_start) begin
            // start stays on through done; the others restart
            o_start_indicator <= 1'b1;
            o_done_indicator  <= 1'b0;
            o_error_indicator <= 1'b0;
         end
         if (byte_done && last_byte(count_reg))
            o_done_indicator <= 1'b1;
         if (overrun)
            o_error_indicator <= 1'b1;
      end
   end
endmodule // sync_serial_slave_receiver

// file: sync_rx_props.sv
// port assertions for the synchronous slave receiver
module sync_rx_props #(parameter WIDTH = 8) (
   input wire             i_core_clk,             // core clock
   input wire             i_reset_n,              // async reset, active low
   input wire             i_module_stop,          // module stop request
   input wire             i_flag_clear,           // request flag clear
   input wire [WIDTH-1:0] o_rx_data,              // receive data register
   input wire             o_rx_full_request_flag, // sticky request flag
   input wire             o_rx_full_irq,          // full request pulse
   input wire             o_rx_error_irq,         // error request pulse
   input wire             o_start_indicator,      // session started
   input wire             o_done_indicator,       // session finished
   input wire             o_error_indicator,      // receive error seen
   input wire             o_running               // channel out of stop
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_reset_n);
   sequence byte_pulse;
      o_rx_full_irq ##1 !o_rx_full_irq;
   endsequence
   a_irq_pulse: assert property (o_rx_full_irq |-> byte_pulse)
      else $error("full request longer than one cycle");
   a_irq_flag: assert property (
      o_rx_full_irq |-> o_rx_full_request_flag)
      else $error("flag not set with full request");
   a_flag_hold: assert property (
      $fell(o_rx_full_request_flag) |-> $past(i_flag_clear))
      else $error("flag dropped without clear");
   a_done_byte: assert property (
      $rose(o_done_indicator) |-> o_rx_full_irq)
      else $error("done without a completed byte");
   a_rx_started: assert property (
      o_rx_full_irq |-> o_start_indicator && $past(o_running))
      else $error("byte outside a running session");
   a_err_byte: assert property (o_rx_error_irq |-> o_rx_full_irq)
      else $error("error request without byte");
   a_err_ind: assert property (
      o_rx_error_irq |-> ##[0:1] o_error_indicator)
      else $error("error indicator not set");
   a_run_unstop: assert property (
      $rose(o_running) |-> !$past(i_module_stop))
      else $error("running while stopped");
   a_stop_halts: assert property (i_module_stop |=> !o_running)
      else $error("stop did not halt channel");
   a_data_byte: assert property (
      $changed(o_rx_data) |-> o_rx_full_irq)
      else $error("data changed without byte");
endmodule // sync_rx_props
bind sync_serial_slave_receiver sync_rx_props #(.WIDTH(WIDTH)) props (.*);

// file: sync_master_model.sv
// external master model driving bit clock and serial data
module sync_master_model #(
   parameter int HALF_NS = 400  // half bit period of the bench link
) (
   output logic o_clk,  // bit clock, still between bytes
   output logic o_data  // serial data
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      o_clk = 1'b0;
      o_data = 1'b1;
   end
   task automatic send(input logic [7:0] b);
      for (int i = 0; i < 8; i++) begin
         o_data = b[i];
         #HALF_NS o_clk = 1'b1;
         #HALF_NS o_clk = 1'b0;
      end
      // released data shows the inverse; gap keeps next byte apart
      o_data = ~b[7];
      #HALF_NS;
   endtask
endmodule // sync_master_model

// file: tb.sv
// self-checking bench for the synchronous slave receiver
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst_n, sck, sd, kwr, stop, en, rd, clr;
   logic [15:0] key;
   logic [7:0] data;
   logic full, irq, eirq, st, dn, er, run;
   int miscompares = 0, checks = 0, n_irq = 0, n_err = 0, cyc = 0;
   sync_master_model master (.o_clk(sck), .o_data(sd));
   sync_serial_slave_receiver DUT (.i_core_clk(clk), .i_reset_n(rst_n),
      .i_sync_clock_in(sck), .i_serial_data_in(sd), .i_key_wr(kwr),
      .i_key_data(key), .i_module_stop(stop), .i_rx_enable(en),
      .i_data_read(rd), .i_flag_clear(clr), .o_rx_data(data),
      .o_rx_full_request_flag(full), .o_rx_full_irq(irq),
      .o_rx_error_irq(eirq), .o_start_indicator(st),
      .o_done_indicator(dn), .o_error_indicator(er), .o_running(run));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (irq === 1'b1) n_irq++;
      if (eirq === 1'b1) n_err++;
      if (cyc == 6000) begin
         miscompares++;
         test_done();
      end
   end
   task automatic chk(input string s, input logic [7:0] e, g);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic strobe(input logic k, r, c);
      @(negedge clk) {kwr, rd, clr} = {k, r, c};
      @(negedge clk) {kwr, rd, clr} = 3'h0;
      repeat (3) @(negedge clk);
   endtask
   task automatic t_unlock;
      chk("reset_outs", 8'h00, {1'b0, run, st, dn, er, full, irq, eirq});
      key = 16'h1234;
      strobe(1'b1, 1'b0, 1'b0);
      chk("run_bad_key", 8'h00, run);
      key = 16'hA502;
      strobe(1'b1, 1'b0, 1'b0);
      chk("run_stopped", 8'h00, run);
      stop = 1'b0;
      en = 1'b1;
      repeat (4) @(negedge clk);
      chk("run_ok", 8'h01, {7'h00, run & st});
      $display("t_unlock done");
   endtask
   task automatic t_session;
      logic [7:0] b, last;
      for (int i = 0; i < 33; i++) begin
         b = 8'h5A + 8'(i * 37);
         master.send(b);
         repeat (8) @(negedge clk);
         chk("rx_data", (i < 32) ? b : last, data);
         chk("flag", (i < 32), full);
         chk("done", (i >= 31), dn);
         if (i < 32) last = b;
         strobe(1'b0, 1'b1, 1'b1);
      end
      chk("flag_clr", 8'h00, full);
      chk("irq_count", 8'h20, 8'(n_irq));
      $display("t_session done");
   endtask
   task automatic t_overrun;
      en = 1'b0;
      repeat (2) @(negedge clk);
      en = 1'b1;
      repeat (4) @(negedge clk);
      chk("done_clr", 8'h00, dn);
      master.send(8'h0F);
      master.send(8'hF0);
      repeat (8) @(negedge clk);
      chk("ovr_data", 8'hF0, data);
      chk("err_ind", 8'h01, er);
      chk("err_irq", 8'h01, 8'(n_err));
      $display("t_overrun done");
   endtask
   task automatic t_stop;
      strobe(1'b0, 1'b1, 1'b1);
      stop = 1'b1;
      repeat (2) @(negedge clk);
      chk("run_stop", 8'h00, run);
      master.send(8'h66);
      repeat (8) @(negedge clk);
      chk("stop_data", 8'hF0, data);
      chk("stop_irq", 8'h22, 8'(n_irq));
      stop = 1'b0;
      repeat (4) @(negedge clk);
      chk("run_again", 8'h01, run);
      master.send(8'h99);
      repeat (8) @(negedge clk);
      chk("restart", 8'h99, data);
      chk("err_clr", 8'h00, er);
      chk("read_ok", 8'h01, 8'(n_err));
      $display("t_stop done");
   endtask
   task automatic test_done;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      {rst_n, kwr, rd, clr, en, stop, key} = {6'h01, 16'h0000};
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      t_unlock();
      t_session();
      t_overrun();
      t_stop();
      test_done();
   end
endmodule // tb
